// ### src/spi_port_pkg.sv
// constants and types shared by the serial port design
// Function
// RULE1 - master drives the serial clock, one cycle per bit, rate selectable
// RULE2 - the serial clock toggles only during a word, idle otherwise
// RULE3 - a slave ignores serial clock while its select input is high
// RULE4 - data launches on one clock edge and is captured on the other
// RULE5 - clock idle polarity and phase are programmable and select the format
// RULE6 - the select input is active low and addresses the port as slave
// RULE7 - a master seeing its select input low flags a multi-master error
// RULE8 - another master may drive our select input from a flag output
// RULE9 - master-out line outputs when master, inputs when slave
// RULE10 - slave-out line inputs when master, outputs when slave
// RULE11 - the open-drain control makes the slave-out line drive open-drain
// RULE12 - the system keeps at most one slave driving the slave-out line
// RULE13 - slave-out disable releases the slave-out line for broadcast
// RULE14 - one bit is received for every bit sent, both over the whole word
package spi_port_pkg;
	localparam int WORD_BITS = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int DIV_BITS = 8;
	localparam int SYNC_STAGES = 3;
	// shortest half period in clk cycles; covers the input synchroniser delay
	localparam logic [DIV_BITS-1:0] MIN_HALF_CYCLES = 8'h06;
	localparam logic [3:0] LAST_EDGE = 4'hf;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 8'h00;
	localparam logic [DIV_BITS-1:0] DIV_RESET = 8'h00;
	typedef logic [WORD_BITS-1:0] word_type;
	typedef enum logic {M_IDLE, M_SHIFT} master_state_type;
endpackage : spi_port_pkg

// ### src/stream_if.sv
// valid/ready word stream between the port modules
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport source (output data, output valid, input ready);
	modport sink (input data, input valid, output ready);
endinterface : stream_if
`default_nettype wire

// ### src/level_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] d,
	output var logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	wire agree = (s2_q == s3_q);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			q <= INIT;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) begin
				q <= s3_q;
			end
		end
	end
endmodule : level_sync
`default_nettype wire

// ### src/stream_fifo.sv
// synchronous word fifo with registered full and empty flags
`timescale 1ns/10ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	stream_if.sink wr,
	stream_if.source rd
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic room_q;
	logic avail_q;

	wire push = wr.valid & room_q;
	wire pop = rd.ready & avail_q;

	assign wr.ready = room_q;
	assign rd.valid = avail_q;
	assign rd.data = mem[rd_ptr_q];
	assign count_d = count_q + CW'(push) - CW'(pop);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= wr.data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			room_q <= 1'b1;
			avail_q <= 1'b0;
		end else begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q <= count_d;
			room_q <= (count_d != FULL_COUNT);
			avail_q <= (count_d != '0);
		end
	end
endmodule : stream_fifo
`default_nettype wire

// ### src/spi_port.sv
// master/slave serial peripheral port with pin direction control
`timescale 1ns/10ps
`default_nettype none
module spi_port (
	input wire logic clk,
	input wire logic sys_rst,
	// configuration, static while a word moves
	input wire logic port_enable,
	input wire logic master_mode,
	input wire logic clock_polarity,
	input wire logic clock_phase,
	input wire logic slave_out_open_drain,
	input wire logic slave_out_disable,
	input wire logic [spi_port_pkg::DIV_BITS-1:0] baud_div,
	input wire logic error_clear,
	// transmit stream into the fifo
	input wire spi_port_pkg::word_type tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// received words
	output spi_port_pkg::word_type rx_data,
	output logic rx_valid,
	output logic busy,
	output logic multi_master_error,
	// serial clock pin, also the clock of the slave domain
	input wire logic serial_clock_pin,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	input wire logic slave_select_in,
	input wire logic master_out_in,
	output logic master_out_out,
	output logic master_out_oe,
	input wire logic slave_out_in,
	output logic slave_out_out,
	output logic slave_out_oe
);
	import spi_port_pkg::*;

	// ------------------------------------------------------------
	// transmit fifo
	// ------------------------------------------------------------
	stream_if #(.WIDTH(WORD_BITS)) fifo_in ();
	stream_if #(.WIDTH(WORD_BITS)) fifo_out ();

	assign fifo_in.data = tx_data;
	assign fifo_in.valid = tx_valid;
	assign tx_ready = fifo_in.ready;

	stream_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr(fifo_in.sink),
		.rd(fifo_out.source)
	);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic select_n_s;
	logic slave_out_s;

	level_sync #(.WIDTH(1), .INIT(1'b1)) select_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(slave_select_in),
		.q(select_n_s)
	);

	level_sync #(.WIDTH(1), .INIT(1'b1)) miso_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(slave_out_in),
		.q(slave_out_s)
	);

	// ------------------------------------------------------------
	// role decode
	// ------------------------------------------------------------
	wire master_on = port_enable & master_mode;
	wire slave_on = port_enable & ~master_mode;
	wire select_low = ~select_n_s; // [RULE6]
	wire error_set = master_on & select_low; // [RULE7]
	wire master_ok = master_on & ~multi_master_error & ~error_set;

	// ------------------------------------------------------------
	// multi-master error, a new detection wins over the clear
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			multi_master_error <= 1'b0;
		end else if (error_set) begin
			multi_master_error <= 1'b1; // [RULE7]
		end else if (error_clear) begin
			multi_master_error <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// master bit-rate divider and edge sequencer
	// ------------------------------------------------------------
	master_state_type m_state_q;
	master_state_type m_state_d;
	logic [DIV_BITS-1:0] div_cnt_q;
	logic [3:0] edge_q;
	word_type m_tx_q;
	word_type m_rx_q;
	logic sck_level_q;
	logic m_done_q;

	// the period is selectable but never shorter than the sampling path
	wire [DIV_BITS-1:0] half_lim =
		(baud_div < MIN_HALF_CYCLES) ? MIN_HALF_CYCLES : baud_div; // [RULE1]
	wire tick = (div_cnt_q == half_lim - 8'h01);
	wire shifting = (m_state_q == M_SHIFT);
	wire at_edge = shifting & tick;
	// even edges lead, odd edges trail; phase picks the launch edge
	wire launch_edge = edge_q[0] ^ clock_phase; // [RULE4]
	wire capture_edge = ~launch_edge; // [RULE4]
	wire last_edge = (edge_q == LAST_EDGE); // [RULE2]
	wire m_start = (m_state_q == M_IDLE) & master_ok & fifo_out.valid;
	wire m_abort = shifting & ~master_ok;

	always_comb begin
		m_state_d = m_state_q;
		unique case (m_state_q)
			M_IDLE: begin
				if (m_start) begin
					m_state_d = M_SHIFT;
				end
			end
			M_SHIFT: begin
				if (m_abort || (at_edge && last_edge)) begin
					m_state_d = M_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			m_state_q <= M_IDLE;
		end else begin
			m_state_q <= m_state_d;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt_q <= DIV_RESET;
			edge_q <= '0;
		end else if (!shifting) begin
			div_cnt_q <= DIV_RESET;
			edge_q <= '0;
		end else if (tick) begin
			div_cnt_q <= DIV_RESET;
			edge_q <= edge_q + 4'h1;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01;
		end
	end

	// clock toggles once per edge, sixteen edges per word, then rests
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sck_level_q <= 1'b0;
		end else if (!shifting) begin
			sck_level_q <= clock_polarity; // [RULE2] [RULE5]
		end else if (tick) begin
			sck_level_q <= ~sck_level_q; // [RULE1]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			m_tx_q <= WORD_RESET;
		end else if (m_start) begin
			m_tx_q <= fifo_out.data;
		end else if (at_edge && launch_edge && edge_q != 4'h0) begin
			m_tx_q <= {m_tx_q[WORD_BITS-2:0], 1'b0}; // [RULE4]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			m_rx_q <= WORD_RESET;
		end else if (at_edge && capture_edge) begin
			m_rx_q <= {m_rx_q[WORD_BITS-2:0], slave_out_s}; // [RULE14]
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			m_done_q <= 1'b0;
		end else begin
			m_done_q <= at_edge & last_edge & master_ok;
		end
	end

	// ------------------------------------------------------------
	// slave transmit word, held stable for the link domain
	// ------------------------------------------------------------
	word_type s_hold_q;
	logic hold_full_q;
	logic s_word_evt;
	wire s_load = slave_on & fifo_out.valid & ~hold_full_q;

	assign fifo_out.ready = m_start | s_load;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_hold_q <= WORD_RESET;
		end else if (s_load) begin
			s_hold_q <= fifo_out.data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_full_q <= 1'b0;
		end else if (s_load) begin
			// a load in the cycle of a word event must not be lost
			hold_full_q <= 1'b1;
		end else if (s_word_evt || !slave_on) begin
			hold_full_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// slave link domain, clocked by the incoming serial clock
	// ------------------------------------------------------------
	// capture on the rising edge of link_cap_clk, launch on its falling
	wire link_cap_clk = serial_clock_pin ^ clock_polarity ^ clock_phase;
	// a high select holds the link logic in reset, so clocks are ignored
	wire link_rst = sys_rst | slave_select_in | ~slave_on; // [RULE3] [RULE6]
	logic [2:0] cap_cnt_q;
	logic [WORD_BITS-2:0] s_rx_q;
	logic s_started_q;
	logic [2:0] bit_idx_q;
	word_type s_word_q;
	logic s_toggle_q;

	always_ff @(posedge link_cap_clk or posedge link_rst) begin
		if (link_rst) begin
			cap_cnt_q <= '0;
			s_rx_q <= '0;
			s_started_q <= 1'b0;
		end else begin
			cap_cnt_q <= cap_cnt_q + 3'h1;
			s_rx_q <= {s_rx_q[WORD_BITS-3:0], master_out_in}; // [RULE14]
			s_started_q <= 1'b1;
		end
	end

	// finished words live outside the select reset so a toggle is never lost
	always_ff @(posedge link_cap_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_word_q <= WORD_RESET;
			s_toggle_q <= 1'b0;
		end else if (!link_rst && cap_cnt_q == LAST_BIT) begin
			s_word_q <= {s_rx_q, master_out_in}; // [RULE4]
			s_toggle_q <= ~s_toggle_q;
		end
	end

	// no launch before the first capture: the first bit is already out
	always_ff @(negedge link_cap_clk or posedge link_rst) begin
		if (link_rst) begin
			bit_idx_q <= '0;
		end else if (s_started_q) begin
			bit_idx_q <= bit_idx_q + 3'h1; // [RULE4]
		end
	end

	wire s_tx_bit = s_hold_q[LAST_BIT - bit_idx_q];

	// ------------------------------------------------------------
	// word-done event into the core domain
	// ------------------------------------------------------------
	logic s_toggle_s;
	logic s_toggle_seen_q;

	level_sync #(.WIDTH(1), .INIT(1'b0)) word_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(s_toggle_q),
		.q(s_toggle_s)
	);

	assign s_word_evt = s_toggle_s ^ s_toggle_seen_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_toggle_seen_q <= 1'b0;
		end else begin
			s_toggle_seen_q <= s_toggle_s;
		end
	end

	// ------------------------------------------------------------
	// received words and status
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_data <= WORD_RESET;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= m_done_q | (s_word_evt & slave_on);
			if (m_done_q) begin
				rx_data <= m_rx_q;
			end else if (s_word_evt) begin
				rx_data <= s_word_q;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy <= 1'b0;
		end else begin
			// follows the state, so it falls in the same cycle the last clock edge reaches the pin
			busy <= shifting | (slave_on & select_low);
		end
	end

	// ------------------------------------------------------------
	// pin direction
	// ------------------------------------------------------------
	logic s_drive_q;
	logic s_od_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_clock_out <= 1'b0;
			serial_clock_oe <= 1'b0;
			master_out_oe <= 1'b0;
			s_drive_q <= 1'b0;
			s_od_q <= 1'b0;
		end else begin
			serial_clock_out <= sck_level_q; // [RULE1]
			serial_clock_oe <= master_ok; // [RULE1]
			master_out_oe <= master_ok; // [RULE9]
			// selected slave drives unless broadcast disable is set
			s_drive_q <= slave_on & select_low & ~slave_out_disable; // [RULE10] [RULE13]
			s_od_q <= slave_out_open_drain; // [RULE11]
		end
	end

	assign master_out_out = m_tx_q[WORD_BITS-1]; // [RULE9]
	// the bit index comes from link-domain flops so the bit follows the serial edges
	assign slave_out_out = s_od_q ? 1'b0 : s_tx_bit; // [RULE10] [RULE11]
	// open drain: only a low bit enables the driver
	assign slave_out_oe = s_drive_q & (~s_od_q | ~s_tx_bit); // [RULE11] [RULE12]
endmodule : spi_port
`default_nettype wire

// ### tb/spi_port_assertions.sv
// pin-level checks of the serial port
`timescale 1ns/10ps
`default_nettype none
module spi_port_assertions (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic port_enable,
	input wire logic master_mode,
	input wire logic clock_polarity,
	input wire logic slave_out_open_drain,
	input wire logic slave_out_disable,
	input wire logic error_clear,
	input wire logic slave_select_in,
	input wire logic busy,
	input wire logic multi_master_error,
	input wire logic serial_clock_out,
	input wire logic serial_clock_oe,
	input wire logic master_out_oe,
	input wire logic slave_out_out,
	input wire logic slave_out_oe
);
	// ----
	// steps
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence edge_s;
		serial_clock_oe && $past(serial_clock_oe) &&
		$changed(serial_clock_out) && $past(clock_polarity, 2) == clock_polarity;
	endsequence
	sequence rival_s;
		(master_mode && port_enable && !slave_select_in) [*6];
	endsequence
	sequence drive_s;
		(master_mode && port_enable && !multi_master_error) [*3];
	endsequence
	sequence desel_s;
		slave_select_in [*6];
	endsequence
	// ----
	// checks
	// ----
	clk_owner_a: assert property (serial_clock_oe |-> master_mode)
		else $error("clock driven while slave");
	half_period_a: assert property (
		edge_s |=> $stable(serial_clock_out) [*5])
		else $error("clock half period short");
	clk_gated_a: assert property (edge_s |-> busy || $past(busy))
		else $error("clock toggled outside a word");
	clk_idle_a: assert property (
		!busy && serial_clock_oe && $stable(clock_polarity)
		|-> serial_clock_out == clock_polarity)
		else $error("clock not at idle level");
	deselect_a: assert property (desel_s |-> !slave_out_oe)
		else $error("slave out driven while deselected");
	mm_flag_a: assert property (rival_s |-> multi_master_error)
		else $error("multi-master error missed");
	mm_sticky_a: assert property (
		multi_master_error && !error_clear |=> multi_master_error)
		else $error("multi-master error lost");
	mosi_drive_a: assert property (drive_s |-> master_out_oe)
		else $error("master out not driven");
	mosi_stop_a: assert property (
		multi_master_error || !master_mode |=> !master_out_oe)
		else $error("master out driven wrongly");
	miso_role_a: assert property (
		slave_out_oe |-> !master_mode && !slave_out_disable)
		else $error("slave out driven wrongly");
	open_drain_a: assert property (
		slave_out_oe && slave_out_open_drain |-> !slave_out_out)
		else $error("slave out drove high");
endmodule : spi_port_assertions
bind spi_port spi_port_assertions chk (.clk, .sys_rst, .port_enable,
	.master_mode, .clock_polarity, .slave_out_open_drain,
	.slave_out_disable, .error_clear, .slave_select_in, .busy,
	.multi_master_error, .serial_clock_out, .serial_clock_oe,
	.master_out_oe, .slave_out_out, .slave_out_oe);
`default_nettype wire

// ### tb/spi_far_end.sv
// far-side serial device, as a slave or as a second master
`timescale 1ns/10ps
`default_nettype none
module spi_far_end (
	input wire logic sck_w,
	input wire logic mosi_w,
	input wire logic miso_w,
	input wire logic cpol,
	input wire logic cpha,
	output var logic sck_d,
	output var logic sck_en,
	output var logic mosi_d,
	output var logic mosi_en,
	output logic miso_d,
	output logic miso_en,
	output var logic sel_n
);
	import spi_port_pkg::*;
	// ----
	// slave side
	// ----
	logic slave_on;
	word_type reply, got, sreg;
	logic [3:0] cnt;
	initial begin
		sck_d = 1'b1;
		sck_en = 1'b0;
		mosi_d = 1'b1;
		mosi_en = 1'b0;
		sel_n = 1'b1;
		slave_on = 1'b0;
	end
	assign miso_en = slave_on;
	assign miso_d = sreg[7];
	always @(sck_w) begin
		if (slave_on) begin
			if ((sck_w != cpol) != cpha) begin
				got = {got[6:0], mosi_w};
			end else if (!(cpha && cnt == 4'h0)) begin
				sreg = {sreg[6:0], !sreg[0]};
			end
			cnt = cnt + 4'h1;
			if (cnt == 4'h0) begin
				sreg = reply;
			end
		end
	end
	task be_slave(input logic on, input word_type w);
		slave_on = on;
		reply = w;
		sreg = w;
		cnt = 4'h0;
	endtask : be_slave
	task select(input logic lvl);
		sel_n = lvl;
	endtask : select
	// ----
	// master side, link clock only within a frame
	// ----
	task xfer(input word_type tx, input logic sel, output word_type rx);
		sck_d = cpol;
		sck_en = 1'b1;
		mosi_en = 1'b1;
		#20 sel_n = !sel;
		#60;
		for (int i = 7; i >= 0; i--) begin
			if (!cpha) mosi_d = tx[i];
			#7.5 sck_d = !cpol;
			if (cpha) mosi_d = tx[i];
			else rx[i] = miso_w;
			#7.5 sck_d = cpol;
			if (cpha) rx[i] = miso_w;
		end
		#60 sel_n = 1'b1;
		#20 sck_en = 1'b0;
		mosi_en = 1'b0;
		#40;
	endtask : xfer
endmodule : spi_far_end
`default_nettype wire

// ### tb/spi_port_bench.sv
// self-checking bench for the serial port
`timescale 1ns/10ps
`default_nettype none
module spi_port_bench;
	import spi_port_pkg::*;
	// ----
	// pins and counters
	// ----
	logic clk, sys_rst, port_enable, master_mode, clock_polarity, clock_phase;
	logic slave_out_open_drain, slave_out_disable, error_clear, tx_valid;
	logic tx_ready, rx_valid, busy, multi_master_error, sel_n;
	logic serial_clock_out, serial_clock_oe, master_out_out, master_out_oe;
	logic slave_out_out, slave_out_oe, fsck, fsck_en, fmo, fmo_en, fmi, fmi_en;
	logic [DIV_BITS-1:0] baud_div;
	word_type tx_data, rx_data, rx_last, fw;
	wire sck_w, mosi_w, miso_w;
	int fails = 0, tests_run = 0, edges = 0, rx_cnt = 0, cyc = 0, base;
	// released lines float high on their pull-ups
	assign sck_w = serial_clock_oe ? serial_clock_out : (fsck_en ? fsck : 1'b1);
	assign mosi_w = master_out_oe ? master_out_out : (fmo_en ? fmo : 1'b1);
	assign miso_w = slave_out_oe ? slave_out_out : (fmi_en ? fmi : 1'b1);
	spi_port dut (.clk, .sys_rst, .port_enable, .master_mode, .clock_polarity,
		.clock_phase, .slave_out_open_drain, .slave_out_disable, .baud_div,
		.error_clear, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
		.busy, .multi_master_error, .serial_clock_pin(sck_w),
		.serial_clock_out, .serial_clock_oe, .slave_select_in(sel_n),
		.master_out_in(mosi_w), .master_out_out, .master_out_oe,
		.slave_out_in(miso_w), .slave_out_out, .slave_out_oe);
	spi_far_end far (.sck_w, .mosi_w, .miso_w, .cpol(clock_polarity),
		.cpha(clock_phase), .sck_d(fsck), .sck_en(fsck_en), .mosi_d(fmo),
		.mosi_en(fmo_en), .miso_d(fmi), .miso_en(fmi_en), .sel_n);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			end_sim();
		end
		if (rx_valid === 1'b1) begin
			rx_cnt <= rx_cnt + 1;
			rx_last <= rx_data;
		end
	end
	always @(sck_w) edges = edges + 1;
	// ----
	// tasks
	// ----
	task check(input string what, input logic [15:0] seen, exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task cfg(input logic m, pol, pha, od, dis);
		port_enable = 1'b0;
		tick(4);
		master_mode = m;
		clock_polarity = pol;
		clock_phase = pha;
		slave_out_open_drain = od;
		slave_out_disable = dis;
		tick(4);
		port_enable = 1'b1;
		tick(10);
		edges = 0;
	endtask : cfg
	task push(input word_type w);
		tx_data = w;
		tx_valid = 1'b1;
		@(posedge clk);
		while (tx_ready !== 1'b1) @(posedge clk);
		#1;
	endtask : push
	task wait_rx(input int n);
		for (int k = 0; k < 3000 && rx_cnt < n; k++) @(posedge clk);
		#1;
	endtask : wait_rx
	task end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	// ----
	// scenarios
	// ----
	initial begin
		sys_rst = 1'b1;
		{port_enable, master_mode, clock_polarity, clock_phase} = 4'h0;
		{slave_out_open_drain, slave_out_disable, error_clear} = 3'h0;
		tx_valid = 1'b0;
		tx_data = 8'h00;
		baud_div = 8'h06;
		tick(8);
		check("reset oe", 16'({serial_clock_oe, master_out_oe, slave_out_oe}),
			16'h0000);
		sys_rst = 1'b0;
		tick(2);
		for (int i = 0; i < 4; i++) begin
			baud_div = i[0] ? 8'h07 : 8'h02;
			cfg(1'b1, i[1], i[0], 1'b0, 1'b0);
			far.be_slave(1'b1, 8'h3c + 8'(i));
			base = rx_cnt;
			push(8'ha0 + 8'(i));
			tx_valid = 1'b0;
			wait_rx(base + 1);
			check("master rx", 16'(rx_last), 16'h003c + 16'(i));
			check("far rx", 16'(far.got), 16'h00a0 + 16'(i));
			check("edges", 16'(edges), 16'h0010);
			check("idle", 16'(sck_w), 16'(clock_polarity));
		end
		far.be_slave(1'b1, 8'h69);
		port_enable = 1'b0;
		tick(4);
		base = rx_cnt;
		for (int i = 0; i < FIFO_DEPTH; i++) push(8'h80 + 8'(i));
		tx_valid = 1'b0;
		tick(2);
		check("full", 16'(tx_ready), 16'h0000);
		port_enable = 1'b1;
		edges = 0;
		wait_rx(base + 16);
		tick(4);
		check("words", 16'(rx_cnt - base), 16'h0010);
		check("last rx", 16'(rx_last), 16'h0069);
		check("edges", 16'(edges), 16'h0100);
		check("far rx", 16'(far.got), 16'h008f);
		check("room", 16'(tx_ready), 16'h0001);
		far.be_slave(1'b0, 8'h00);
		far.select(1'b0);
		tick(10);
		check("error", 16'(multi_master_error), 16'h0001);
		check("mosi oe", 16'(master_out_oe), 16'h0000);
		far.select(1'b1);
		tick(8);
		error_clear = 1'b1;
		tick(1);
		error_clear = 1'b0;
		tick(2);
		check("cleared", 16'(multi_master_error), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			cfg(1'b0, i[1], i[0], i == 2, i == 1);
			push(8'h90 + 8'(i));
			tx_valid = 1'b0;
			base = rx_cnt;
			far.xfer(8'hc0 + 8'(i), 1'b1, fw);
			far.xfer(8'hd0 + 8'(i), 1'b1, fw);
			wait_rx(base + 2);
			check("slave words", 16'(rx_cnt - base), 16'h0002);
			check("slave rx", 16'(rx_last), 16'h00d0 + 16'(i));
			check("slave tx", 16'(fw),
				(i == 1) ? 16'h00ff : 16'h0090 + 16'(i));
			check("pin oe", 16'({serial_clock_oe, master_out_oe}), 16'h0000);
		end
		base = rx_cnt;
		far.xfer(8'h55, 1'b0, fw);
		tick(20);
		check("ignored", 16'(rx_cnt - base), 16'h0000);
		end_sim();
	end
endmodule : spi_port_bench
`default_nettype wire
